// >>> shared/bmc_pkg.sv
// Constants and carrier types for the basic mode control register bank.
// Assumes a single 50 MHz management clock shared by every user of the bank.
package bmc_pkg;

    // ==========================================================
    // Register map
    localparam logic [4:0] BMC_ADDR_BASIC_MODE_CONTROL = 5'h00;

    // ==========================================================
    // Field positions
    localparam int BMC_BIT_RESET = 15;
    localparam int BMC_BIT_LOOPBACK = 14;
    localparam int BMC_BIT_SPEED = 13;
    localparam int BMC_BIT_AN_ENABLE = 12;
    localparam int BMC_BIT_POWER_DOWN = 11;
    localparam int BMC_BIT_ISOLATE = 10;
    localparam int BMC_BIT_AN_RESTART = 9;
    localparam int BMC_BIT_DUPLEX = 8;
    localparam int BMC_BIT_COLL_TEST = 7;
    localparam int BMC_BIT_UNIDIR = 5;

    // Writable bits; 6 and 4:0 are reserved and read as zero
    localparam logic [15:0] BMC_WRITE_MASK = 16'hFFA0;

    // ==========================================================
    // Reset values of the non-strapped bits
    localparam logic BMC_RST_LOOPBACK = 1'b0;
    localparam logic BMC_RST_POWER_DOWN = 1'b0;
    localparam logic BMC_RST_ISOLATE = 1'b0;
    localparam logic BMC_RST_AN_RESTART = 1'b0;
    localparam logic BMC_RST_COLL_TEST = 1'b0;
    localparam logic BMC_RST_UNIDIR = 1'b0;
    // Strap sync register reset: straps low, power-down pin released
    localparam logic [4:0] BMC_RST_PINS = 5'h10;

    // ==========================================================
    // Timing
    localparam int BMC_CLK_MHZ = 50;
    localparam int BMC_SOFT_RESET_NS = 1000;
    localparam int BMC_SOFT_RESET_CYC = (BMC_SOFT_RESET_NS * BMC_CLK_MHZ + 999) / 1000;
    localparam int BMC_LOOPBACK_DEAD_US = 500;
    localparam int BMC_LOOPBACK_DEAD_CYC = BMC_LOOPBACK_DEAD_US * BMC_CLK_MHZ;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] addr;
        logic [15:0] wdata;
    } bmc_mgmt_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] rdata;
    } bmc_mgmt_rsp_t;

    typedef struct packed {
        logic fiber_mode_enable;
        logic an_enable;
        logic duplex_full;
        logic speed_100;
    } bmc_strap_t;

    typedef struct packed {
        logic core_reset;
        logic loopback;
        logic rx_dead;
        logic an_enable;
        logic an_restart;
        logic speed_100;
        logic duplex_full;
        logic power_down;
        logic isolate;
        logic tx_allowed;
    } bmc_ctrl_t;

endpackage : bmc_pkg

// >>> verilog/bmc_basic_mode_control.sv
// Basic mode control register of a fast Ethernet transceiver.
// Assumes a word-wide management request port decoded from the serial
// management frame engine, and a MAC interface on the same clock.
//
// Notes on behaviour
// - Writing one to bit 15 starts soft reset; reads one until done; straps resampled.
// - Bit 14 set routes MAC transmit data back to the MAC receive path.
// - Enabling loopback may blank valid receive data for up to 500 us.
// - With negotiation off, bit 13 picks 100 or 10 Mb/s; reset value strapped.
// - Bit 12 loads from strap at reset; forced zero while fiber mode enabled.
// - Negotiation on ignores bits 13 and 8; off, they set speed and duplex.
// - Bit 11 powers the transceiver down; only the register block stays alive.
// - Power down is bit 11 OR the low pin; the pin also sets bit 11.
// - Bit 10 isolates the port from the MAC; management stays working.
// - Bit 9 restarts negotiation, reads one until started, ignored if negotiation off.
// - Clearing bit 9 by a write never aborts a running negotiation.
// - With negotiation off, bit 8 picks full or half duplex; reset value strapped.
// - Bit 7 drives collision within 512 bit times of transmit enable, drops within 4.
// - Bits 6 and 4:0 ignore writes and read zero.
// - Bit 5 allows 100 Mb/s transmit without link; no effect at 10 Mb/s.
// - Self-clearing bits set by their trigger and clear when the operation ends.
`timescale 1ns/1ns
`default_nettype none

module bmc_basic_mode_control #(
    parameter int SOFT_RESET_CYCLES = bmc_pkg::BMC_SOFT_RESET_CYC,
    parameter int LOOPBACK_DEAD_CYCLES = bmc_pkg::BMC_LOOPBACK_DEAD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire bmc_pkg::bmc_mgmt_req_t mgmt_req,
    output bmc_pkg::bmc_mgmt_rsp_t mgmt_rsp,
    input wire bmc_pkg::bmc_strap_t strap_pins,
    input wire logic power_down_pin_n,
    input wire logic an_started,
    input wire logic an_result_speed_100,
    input wire logic an_result_duplex_full,
    input wire logic link_up,
    input wire logic mac_tx_en,
    output logic mac_col,
    output bmc_pkg::bmc_ctrl_t ctrl
);
    import bmc_pkg::*;

    localparam int RST_W = $clog2(SOFT_RESET_CYCLES + 1);
    localparam int DEAD_W = $clog2(LOOPBACK_DEAD_CYCLES + 1);
    localparam logic [RST_W-1:0] RST_LOAD = RST_W'(SOFT_RESET_CYCLES);
    localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(LOOPBACK_DEAD_CYCLES);

    // ==========================================================
    // Elaboration checks
    // Filter needs four edges to fill after power on; the strap load uses the fifth
    if (SOFT_RESET_CYCLES < 5) begin : g_bad_reset
        $error("soft reset must outlast the pin filter filling after reset");
    end
    if (LOOPBACK_DEAD_CYCLES < 1) begin : g_bad_dead
        $error("loopback dead interval must be at least one cycle");
    end

    // ==========================================================
    // State
    typedef struct packed {
        logic [4:0] pin_s1;
        logic [4:0] pin_s2;
        logic [4:0] pin_s3;
        logic [4:0] pin_stable;
        logic busy;
        logic [RST_W-1:0] rst_cnt;
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic an_restart;
        logic duplex_full;
        logic coll_test;
        logic unidir;
        logic [DEAD_W-1:0] dead_cnt;
        logic col;
        logic rsp_valid;
        logic [15:0] rdata;
    } bmc_state_t;

    bmc_state_t st_q;
    bmc_state_t st_d;

    function automatic logic [15:0] bmc_pack(input bmc_state_t s);
        logic [15:0] v;
        v = 16'h0000;
        v[BMC_BIT_RESET] = s.busy;
        v[BMC_BIT_LOOPBACK] = s.loopback;
        v[BMC_BIT_SPEED] = s.speed_100;
        v[BMC_BIT_AN_ENABLE] = s.an_enable;
        v[BMC_BIT_POWER_DOWN] = s.power_down;
        v[BMC_BIT_ISOLATE] = s.isolate;
        v[BMC_BIT_AN_RESTART] = s.an_restart;
        v[BMC_BIT_DUPLEX] = s.duplex_full;
        v[BMC_BIT_COLL_TEST] = s.coll_test;
        v[BMC_BIT_UNIDIR] = s.unidir;
        return v & BMC_WRITE_MASK;
    endfunction : bmc_pack

    logic wr_hit;
    logic [15:0] wd;
    logic pd_pin_active;
    logic eff_speed;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        wd = mgmt_req.wdata;
        wr_hit = mgmt_req.valid && mgmt_req.write && !st_q.busy
            && (mgmt_req.addr == BMC_ADDR_BASIC_MODE_CONTROL);

        // Pins: three flops, a change counts when stages two and three agree
        st_d.pin_s1 = {power_down_pin_n, strap_pins};
        st_d.pin_s2 = st_q.pin_s1;
        st_d.pin_s3 = st_q.pin_s2;
        if (st_q.pin_s2 == st_q.pin_s3) begin
            st_d.pin_stable = st_q.pin_s3;
        end
        pd_pin_active = !st_q.pin_stable[4];

        // Read answer shows the value before any write in the same request
        st_d.rsp_valid = mgmt_req.valid;
        st_d.rdata = 16'h0000;
        if (mgmt_req.valid && !mgmt_req.write
                && mgmt_req.addr == BMC_ADDR_BASIC_MODE_CONTROL) begin
            st_d.rdata = bmc_pack(st_q);
        end

        if (wr_hit) begin
            st_d.loopback = wd[BMC_BIT_LOOPBACK];
            st_d.speed_100 = wd[BMC_BIT_SPEED];
            st_d.an_enable = wd[BMC_BIT_AN_ENABLE];
            st_d.power_down = wd[BMC_BIT_POWER_DOWN];
            st_d.isolate = wd[BMC_BIT_ISOLATE];
            st_d.duplex_full = wd[BMC_BIT_DUPLEX];
            st_d.coll_test = wd[BMC_BIT_COLL_TEST];
            st_d.unidir = wd[BMC_BIT_UNIDIR];
            // Clearing only hides the request; the engine keeps running
            if (!wd[BMC_BIT_AN_RESTART]) begin
                st_d.an_restart = 1'b0;
            end
            if (wd[BMC_BIT_RESET]) begin
                st_d.busy = 1'b1;
                st_d.rst_cnt = RST_LOAD;
            end
        end

        // Restart drops once the engine reports it started
        if (st_q.an_restart && an_started) begin
            st_d.an_restart = 1'b0;
        end
        // Set wins over both clears
        if (wr_hit && wd[BMC_BIT_AN_RESTART] && st_d.an_enable) begin
            st_d.an_restart = 1'b1;
        end
        if (!st_d.an_enable) begin
            st_d.an_restart = 1'b0;
        end

        // Soft reset: hold, then reload defaults and resample straps
        if (st_q.busy) begin
            st_d.rst_cnt = st_q.rst_cnt - RST_W'(1);
            if (st_q.rst_cnt == RST_W'(1)) begin
                st_d.busy = 1'b0;
                st_d.loopback = BMC_RST_LOOPBACK;
                st_d.power_down = BMC_RST_POWER_DOWN;
                st_d.isolate = BMC_RST_ISOLATE;
                st_d.an_restart = BMC_RST_AN_RESTART;
                st_d.coll_test = BMC_RST_COLL_TEST;
                st_d.unidir = BMC_RST_UNIDIR;
                st_d.speed_100 = st_q.pin_stable[0];
                st_d.duplex_full = st_q.pin_stable[1];
                st_d.an_enable = st_q.pin_stable[2];
            end
        end

        if (st_q.pin_stable[3]) begin
            st_d.an_enable = 1'b0;
            st_d.an_restart = 1'b0;
        end
        if (pd_pin_active) begin
            st_d.power_down = 1'b1;
        end

        // Dead interval starts on the rising edge of loopback
        if (st_d.loopback && !st_q.loopback) begin
            st_d.dead_cnt = DEAD_LOAD;
        end else if (st_q.dead_cnt != '0) begin
            st_d.dead_cnt = st_q.dead_cnt - DEAD_W'(1);
        end

        // One cycle is far inside both the 512 and 4 bit time limits
        st_d.col = st_q.coll_test && mac_tx_en;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.pin_s1 <= BMC_RST_PINS;
            st_q.pin_s2 <= BMC_RST_PINS;
            st_q.pin_s3 <= BMC_RST_PINS;
            st_q.pin_stable <= BMC_RST_PINS;
            // Hardware reset runs the soft reset path so straps get sampled
            st_q.busy <= 1'b1;
            st_q.rst_cnt <= RST_LOAD;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs
    assign eff_speed = st_q.an_enable ? an_result_speed_100 : st_q.speed_100;
    assign mgmt_rsp.valid = st_q.rsp_valid;
    assign mgmt_rsp.rdata = st_q.rdata;
    assign mac_col = st_q.col;
    assign ctrl.core_reset = st_q.busy;
    assign ctrl.loopback = st_q.loopback;
    assign ctrl.rx_dead = (st_q.dead_cnt != '0);
    assign ctrl.an_enable = st_q.an_enable;
    assign ctrl.an_restart = st_q.an_restart;
    assign ctrl.speed_100 = eff_speed;
    assign ctrl.duplex_full = st_q.an_enable ? an_result_duplex_full
        : st_q.duplex_full;
    assign ctrl.power_down = st_q.power_down || !st_q.pin_stable[4];
    assign ctrl.isolate = st_q.isolate;
    assign ctrl.tx_allowed = !eff_speed || st_q.unidir || link_up;

endmodule : bmc_basic_mode_control

`default_nettype wire

// >>> tb/bmc_properties.sv
// Concurrent checks of the basic mode control bank at its ports.
// Assumes one clock domain; bound to the bank below the module.
`timescale 1ns/1ns
`default_nettype none
module bmc_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire bmc_pkg::bmc_mgmt_req_t mgmt_req,
    input wire bmc_pkg::bmc_mgmt_rsp_t mgmt_rsp,
    input wire bmc_pkg::bmc_strap_t strap_pins,
    input wire logic power_down_pin_n,
    input wire logic an_started,
    input wire logic an_result_speed_100,
    input wire logic an_result_duplex_full,
    input wire logic link_up,
    input wire logic mac_tx_en,
    input wire logic mac_col,
    input wire bmc_pkg::bmc_ctrl_t ctrl
);
    import bmc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // Properties
    rsp_one_cycle_a: assert property (mgmt_rsp.valid == $past(mgmt_req.valid))
        else $error("answer not one cycle after request");
    reserved_zero_a: assert property (mgmt_rsp.valid |-> (mgmt_rsp.rdata & 16'h005F) == 16'h0000)
        else $error("reserved bits read nonzero");
    busy_reads_a: assert property (ctrl.core_reset && mgmt_req.valid
        && !mgmt_req.write && mgmt_req.addr == 5'h00 |=> mgmt_rsp.rdata[15])
        else $error("busy reset bit read zero");
    col_drop_a: assert property (!mac_tx_en |=> !mac_col)
        else $error("collision without transmit enable");
    an_result_a: assert property (ctrl.an_enable |->
        ctrl.speed_100 == an_result_speed_100 && ctrl.duplex_full == an_result_duplex_full)
        else $error("negotiated result not used");
    tx_allow_a: assert property ((!ctrl.speed_100 || link_up) |-> ctrl.tx_allowed)
        else $error("transmit blocked");
    pin_power_a: assert property (!power_down_pin_n [*5] |-> ctrl.power_down)
        else $error("pin did not power down");
    fiber_an_a: assert property (strap_pins.fiber_mode_enable [*6] |-> !ctrl.an_enable)
        else $error("negotiation on in fiber mode");
    restart_done_a: assert property (ctrl.an_restart && an_started
        && !mgmt_req.valid |-> ##[1:2] !ctrl.an_restart)
        else $error("restart did not self clear");
    dead_start_a: assert property ($rose(ctrl.loopback) |-> ##[0:1] ctrl.rx_dead)
        else $error("no dead interval on loopback");
    cover property (ctrl.core_reset && mgmt_rsp.valid);
    cover property (mac_col);
    cover property (ctrl.an_restart && an_started);
endmodule : bmc_properties

bind bmc_basic_mode_control bmc_properties chk_u (.clk(clk), .resetn(resetn),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp), .strap_pins(strap_pins),
    .power_down_pin_n(power_down_pin_n), .an_started(an_started),
    .an_result_speed_100(an_result_speed_100), .an_result_duplex_full(an_result_duplex_full),
    .link_up(link_up), .mac_tx_en(mac_tx_en), .mac_col(mac_col), .ctrl(ctrl));
`default_nettype wire

// >>> tb/bmc_mgmt_host.sv
// Station management controller model for the register port.
// Assumes answers come one cycle after the request edge.
`timescale 1ns/1ns
`default_nettype none
module bmc_mgmt_host (
    input wire logic clk,
    output bmc_pkg::bmc_mgmt_req_t mgmt_req,
    input wire bmc_pkg::bmc_mgmt_rsp_t mgmt_rsp
);
    import bmc_pkg::*;
    initial mgmt_req = '0;
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(posedge clk);
        #2 mgmt_req = '{1'b1, w, a, d};
        @(posedge clk);
        #2 q = mgmt_rsp.valid ? mgmt_rsp.rdata : 16'hDEAD;
        // Released lines carry the inverse so stale values are never trusted
        mgmt_req = '{1'b0, ~w, ~a, ~d};
    endtask : xfer
    // No configuration write until the reset bit reads zero
    task automatic poll(output logic ok);
        logic [15:0] q;
        ok = 1'b0;
        for (int i = 0; i < 64 && !ok; i++) begin
            xfer(1'b0, 5'h00, 16'h0000, q);
            ok = (q[15] === 1'b0);
        end
    endtask : poll
endmodule : bmc_mgmt_host
`default_nettype wire

// >>> tb/phy_basic_mode_control_test.sv
// Self-checking bench for the basic mode control register bank.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ns
`default_nettype none
module phy_basic_mode_control_test;
    import bmc_pkg::*;
    logic clk, resetn, pin_n, an_started, an_spd, an_dup, link_up, tx_en, col, ok;
    bmc_mgmt_req_t req;
    bmc_mgmt_rsp_t rsp;
    bmc_strap_t straps;
    bmc_ctrl_t ctrl;
    logic [15:0] q;
    int err_total, tests_run;
    bmc_basic_mode_control #(.SOFT_RESET_CYCLES(5), .LOOPBACK_DEAD_CYCLES(8)) dut_u (
        .clk(clk), .resetn(resetn), .mgmt_req(req), .mgmt_rsp(rsp),
        .strap_pins(straps), .power_down_pin_n(pin_n), .an_started(an_started),
        .an_result_speed_100(an_spd), .an_result_duplex_full(an_dup),
        .link_up(link_up), .mac_tx_en(tx_en), .mac_col(col), .ctrl(ctrl));
    bmc_mgmt_host host_u (.clk(clk), .mgmt_req(req), .mgmt_rsp(rsp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic c, input string m);
        tests_run++;
        if (c !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : check
    task automatic summarize();
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic rd();
        host_u.xfer(1'b0, 5'h00, 16'h0000, q);
    endtask : rd
    task automatic wr(input logic [15:0] d);
        logic [15:0] x;
        host_u.xfer(1'b1, 5'h00, d, x);
    endtask : wr
    task automatic wait_idle();
        host_u.poll(ok);
        check(ok, "reset bit stuck");
        if (!ok) summarize();
    endtask : wait_idle
    // ==========================================
    // Scenarios
    task automatic t_fields();
        wr(16'h4CFF);
        check(ctrl.loopback === 1'b1 && ctrl.isolate === 1'b1, "loopback/isolate");
        check(ctrl.power_down === 1'b1 && ctrl.rx_dead === 1'b1, "power/dead");
        check(ctrl.speed_100 === 1'b0 && ctrl.duplex_full === 1'b0, "10 half");
        rd();
        check(q === 16'h4CA0, "reserved bits");
        tx_en = 1'b1;
        repeat (2) @(posedge clk);
        #2 check(col === 1'b1, "collision test on");
        tx_en = 1'b0;
        repeat (2) @(posedge clk);
        #2 check(col === 1'b0, "collision test off");
        check(ctrl.rx_dead === 1'b1, "dead interval too short");
        wr(16'h2100);
        check(ctrl.rx_dead === 1'b0, "dead interval too long");
        check(ctrl.speed_100 === 1'b1 && ctrl.duplex_full === 1'b1, "100 full");
        check(ctrl.tx_allowed === 1'b0, "no link blocks");
        wr(16'h2120);
        check(ctrl.tx_allowed === 1'b1, "unidirectional");
        tx_en = 1'b1;
        repeat (2) @(posedge clk);
        #2 check(col === 1'b0, "collision with test off");
        tx_en = 1'b0;
    endtask : t_fields
    task automatic t_restart();
        wr(16'h0200);
        check(ctrl.an_restart === 1'b0, "restart ignored");
        wr(16'h3300);
        check(ctrl.an_restart === 1'b1 && ctrl.speed_100 === 1'b0
            && ctrl.duplex_full === 1'b0, "restart");
        wr(16'h3100);
        rd();
        check(q === 16'h3100, "restart cleared by write");
        wr(16'h3300);
        an_started = 1'b1;
        @(posedge clk);
        #2 an_started = 1'b0;
        rd();
        check(q === 16'h3100, "restart self clear");
    endtask : t_restart
    task automatic t_pin();
        wr(16'h0000);
        pin_n = 1'b0;
        repeat (6) @(posedge clk);
        #2 check(ctrl.power_down === 1'b1, "pin power down");
        pin_n = 1'b1;
        rd();
        check(q === 16'h0800, "pin sets bit");
    endtask : t_pin
    task automatic t_soft();
        straps = 4'hD;
        wr(16'h8000);
        rd();
        check(q[15] === 1'b1 && ctrl.core_reset === 1'b1, "reset busy");
        wait_idle();
        rd();
        check(q === 16'h2000, "restrap fiber");
        check(ctrl.core_reset === 1'b0 && ctrl.an_enable === 1'b0, "reset end, fiber");
        host_u.xfer(1'b1, 5'h03, 16'hFFFF, q);
        host_u.xfer(1'b0, 5'h03, 16'h0000, q);
        check(q === 16'h0000, "unmapped address");
    endtask : t_soft
    initial begin
        err_total = 0;
        tests_run = 0;
        {resetn, an_started, an_spd, an_dup, link_up, tx_en} = '0;
        pin_n = 1'b1;
        straps = 4'h6;
        repeat (16) @(posedge clk);
        #2 resetn = 1'b1;
        wait_idle();
        rd();
        check(q === 16'h1100, "strapped reset value");
        t_fields();
        t_restart();
        t_pin();
        t_soft();
        summarize();
    end
endmodule : phy_basic_mode_control_test
`default_nettype wire
